//--- out_card.sv
// Output side of the isolated output card: output lines, start levels,
// safe state, watchdog, hot reset handling, status and identifier read-back.
// Assumes an AXI4-Lite master on clk; hot reset, jumper and switch are pins.
`timescale 1ns/1ns
module out_card (
   input wire logic clk,
   input wire logic rst,
   input wire logic [card_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [card_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic hot_reset,
   input wire logic retain_jumper,
   input wire logic [card_pkg::ID_W-1:0] card_identifier_switch,
   output logic [card_pkg::NUM_LINES-1:0] dout,
   output logic dout_en,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Decode helpers
   function automatic logic in_block(input logic [7:0] addr, input logic [7:0] base);
      in_block = (addr[7:4] == base[7:4]);
   endfunction : in_block

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = data[b*8 +: 8];
         end
      end
      merge = res;
   endfunction : merge

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic hot_s1_q, hot_s2_q, hot_prev_q;
   logic ret_s1_q, ret_s2_q;
   logic [card_pkg::ID_W-1:0] id_s1_q, id_s2_q;
   logic hot_rise;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hot_s1_q <= 1'b0;
         hot_s2_q <= 1'b0;
         hot_prev_q <= 1'b0;
         ret_s1_q <= 1'b0;
         ret_s2_q <= 1'b0;
         id_s1_q <= '0;
         id_s2_q <= '0;
      end else begin
         hot_s1_q <= hot_reset;
         hot_s2_q <= hot_s1_q;
         hot_prev_q <= hot_s2_q;
         ret_s1_q <= retain_jumper;
         ret_s2_q <= ret_s1_q;
         id_s1_q <= card_identifier_switch;
         id_s2_q <= id_s1_q;
      end
   end

   assign hot_rise = hot_s2_q && !hot_prev_q;

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel: address and data are caught in either order
   logic aw_hold_q, w_hold_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic wr_fire, wr_mapped, wr_discard, wr_ok;
   logic [1:0] wr_word;
   card_pkg::wdog_stat_type wdog_stat;

   assign s_axi_awready = !aw_hold_q;
   assign s_axi_wready = !w_hold_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
   assign wr_word = aw_addr_q[3:2];
   assign wr_mapped = in_block(aw_addr_q, card_pkg::OFF_OUT) ||
                      in_block(aw_addr_q, card_pkg::OFF_PWR) ||
                      in_block(aw_addr_q, card_pkg::OFF_SAFE) ||
                      in_block(aw_addr_q, card_pkg::OFF_PERIOD) ||
                      aw_addr_q == card_pkg::OFF_STATUS ||
                      aw_addr_q == card_pkg::OFF_MASK ||
                      aw_addr_q == card_pkg::OFF_ID;
   // only the way out (disable) and interrupt upkeep pass when expired
   assign wr_discard = wdog_stat.expired && aw_addr_q != card_pkg::OFF_CTRL &&
                       aw_addr_q != card_pkg::OFF_STATUS && aw_addr_q != card_pkg::OFF_MASK;
   assign wr_ok = wr_fire && !wr_discard;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_hold_q <= 1'b0;
         aw_addr_q <= 8'h00;
      end else if (s_axi_awvalid && !aw_hold_q) begin
         aw_hold_q <= 1'b1;
         aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
      end else if (wr_fire) begin
         aw_hold_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         w_hold_q <= 1'b0;
         w_data_q <= card_pkg::RST_WORD;
         w_strb_q <= 4'h0;
      end else if (s_axi_wvalid && !w_hold_q) begin
         w_hold_q <= 1'b1;
         w_data_q <= s_axi_wdata;
         w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_hold_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bvalid_q <= 1'b0;
         bresp_q <= card_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_mapped ? card_pkg::RESP_OKAY : card_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Start levels, safe state and watchdog settings
   logic [card_pkg::NUM_LINES-1:0] pwr_q, safe_q, out_q;
   logic [31:0] period_q;
   logic wd_en_q, clear_q;
   card_pkg::wdog_cmd_type wdog_cmd;

   // per-line start levels, zero until written
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pwr_q <= '0;
      end else if (wr_ok && in_block(aw_addr_q, card_pkg::OFF_PWR)) begin
         pwr_q[wr_word*32 +: 32] <= merge(pwr_q[wr_word*32 +: 32], w_data_q, w_strb_q);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         safe_q <= '0;
      end else if (wr_ok && in_block(aw_addr_q, card_pkg::OFF_SAFE)) begin
         safe_q[wr_word*32 +: 32] <= merge(safe_q[wr_word*32 +: 32], w_data_q, w_strb_q);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         period_q <= card_pkg::RST_PERIOD;
      end else if (wr_ok && aw_addr_q == card_pkg::OFF_PERIOD) begin
         period_q <= merge(period_q, w_data_q, w_strb_q);
      end
   end

   // Hot reset also stops the watchdog; an expiry already in force still restores the safe state one cycle after the reload
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wd_en_q <= 1'b0;
      end else if (hot_rise) begin
         wd_en_q <= 1'b0;
      end else if (wr_ok && aw_addr_q == card_pkg::OFF_CTRL && w_strb_q[0]) begin
         wd_en_q <= w_data_q[card_pkg::CTRL_EN_BIT];
      end
   end

   // any write to the clear register that is not dropped while expired is a clear command
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clear_q <= 1'b0;
      end else begin
         clear_q <= wr_ok && aw_addr_q == card_pkg::OFF_CLEAR;
      end
   end

   assign wdog_cmd.enable = wd_en_q;
   assign wdog_cmd.clear = clear_q;
   assign wdog_cmd.period = period_q;

   wdog_timer u_wdog (
      .clk(clk),
      .rst(rst),
      .cmd(wdog_cmd),
      .stat(wdog_stat)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Output lines
   logic init_q, drv_en_q;

   // one cycle to load the start levels before drivers turn on
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         init_q <= 1'b1;
         drv_en_q <= 1'b0;
      end else begin
         init_q <= 1'b0;
         if (init_q) begin
            drv_en_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         out_q <= '0;
      end else if (init_q) begin
         out_q <= pwr_q;
      // jumper low reloads start levels, high retains
      end else if (hot_rise && !ret_s2_q) begin
         out_q <= pwr_q;
      end else if (wdog_stat.expired) begin
         out_q <= safe_q;
      end else if (wr_ok && in_block(aw_addr_q, card_pkg::OFF_OUT)) begin
         out_q[wr_word*32 +: 32] <= merge(out_q[wr_word*32 +: 32], w_data_q, w_strb_q);
      end
   end

   assign dout = out_q;
   assign dout_en = drv_en_q;

   ////////////////////////////////////////////////////////////////////////////
   // Sticky status, mask and interrupt; a set in the clearing cycle wins
   logic [card_pkg::ST_W-1:0] status_q, mask_q, st_set, st_clr;
   logic exp_prev_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         exp_prev_q <= 1'b0;
      end else begin
         exp_prev_q <= wdog_stat.expired;
      end
   end

   always_comb begin
      st_set = '0;
      st_set[card_pkg::ST_EXPIRED] = wdog_stat.expired && !exp_prev_q;
      st_set[card_pkg::ST_DISCARD] = wr_fire && wr_discard;
      st_set[card_pkg::ST_HOTRST] = hot_rise;
      st_clr = '0;
      if (wr_ok && aw_addr_q == card_pkg::OFF_STATUS && w_strb_q[0]) begin
         st_clr = w_data_q[card_pkg::ST_W-1:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status_q <= card_pkg::RST_STATUS;
      end else begin
         status_q <= (status_q & ~st_clr) | st_set;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mask_q <= card_pkg::RST_MASK;
      end else if (wr_ok && aw_addr_q == card_pkg::OFF_MASK && w_strb_q[0]) begin
         mask_q <= w_data_q[card_pkg::ST_W-1:0];
      end
   end

   assign irq = |(status_q & mask_q);

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel, answer one cycle after the address is taken
   logic rvalid_q;
   logic [31:0] rdata_q, rd_word;
   logic [1:0] rresp_q, rd_resp;
   logic [7:0] ar_addr;

   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign ar_addr = {s_axi_araddr[7:2], 2'b00};

   always_comb begin
      rd_word = card_pkg::RST_WORD;
      rd_resp = card_pkg::RESP_OKAY;
      if (in_block(ar_addr, card_pkg::OFF_OUT)) begin
         rd_word = out_q[ar_addr[3:2]*32 +: 32];
      end else if (in_block(ar_addr, card_pkg::OFF_PWR)) begin
         rd_word = pwr_q[ar_addr[3:2]*32 +: 32];
      end else if (in_block(ar_addr, card_pkg::OFF_SAFE)) begin
         rd_word = safe_q[ar_addr[3:2]*32 +: 32];
      end else if (ar_addr == card_pkg::OFF_PERIOD) begin
         rd_word = period_q;
      end else if (ar_addr == card_pkg::OFF_CTRL) begin
         rd_word[card_pkg::CTRL_EN_BIT] = wd_en_q;
      end else if (ar_addr == card_pkg::OFF_CLEAR) begin
         rd_word = card_pkg::RST_WORD;
      end else if (ar_addr == card_pkg::OFF_COUNT) begin
         rd_word = wdog_stat.count;
      end else if (ar_addr == card_pkg::OFF_STATUS) begin
         rd_word[card_pkg::ST_W-1:0] = status_q;
      end else if (ar_addr == card_pkg::OFF_MASK) begin
         rd_word[card_pkg::ST_W-1:0] = mask_q;
      end else if (ar_addr == card_pkg::OFF_ID) begin
         rd_word[card_pkg::ID_W-1:0] = id_s2_q;
      end else begin
         rd_resp = card_pkg::RESP_SLVERR;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rvalid_q <= 1'b0;
         rdata_q <= card_pkg::RST_WORD;
         rresp_q <= card_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_word;
         rresp_q <= rd_resp;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_drv_held_off: assert property (@(posedge clk) disable iff (rst)
      init_q |-> !dout_en)
      else $error("output drivers on before start state loaded");
   a_start_levels: assert property (@(posedge clk) disable iff (rst)
      init_q |=> dout_en && dout == $past(pwr_q))
      else $error("start levels not loaded when drivers turn on");
   a_safe_state: assert property (@(posedge clk) disable iff (rst)
      wdog_stat.expired && !hot_rise && !init_q |=> dout == $past(safe_q))
      else $error("outputs left the safe state while expired");
   a_discard_write: assert property (@(posedge clk) disable iff (rst)
      wr_fire && wdog_stat.expired && aw_addr_q != card_pkg::OFF_CTRL
      |=> $stable(pwr_q) && $stable(period_q) && $stable(safe_q))
      else $error("write taken while watchdog expired");
   a_hot_reload: assert property (@(posedge clk) disable iff (rst)
      hot_rise && !ret_s2_q && !init_q |=> dout == $past(pwr_q))
      else $error("hot reset did not reload start levels");
   a_hot_retain: assert property (@(posedge clk) disable iff (rst)
      hot_rise && ret_s2_q && !init_q && !wdog_stat.expired && !wr_fire
      |=> $stable(dout))
      else $error("hot reset changed retained outputs");
   a_out_readback: assert property (@(posedge clk) disable iff (rst)
      s_axi_arvalid && s_axi_arready && ar_addr == card_pkg::OFF_OUT
      |=> s_axi_rvalid && s_axi_rdata == $past(out_q[31:0]))
      else $error("output read-back mismatch");
   a_id_read: assert property (@(posedge clk) disable iff (rst)
      s_axi_arvalid && s_axi_arready && ar_addr == card_pkg::OFF_ID
      |=> s_axi_rdata[card_pkg::ID_W-1:0] == $past(id_s2_q))
      else $error("identifier switch read mismatch");
   a_clear_restart: assert property (@(posedge clk) disable iff (rst)
      wr_ok && aw_addr_q == card_pkg::OFF_CLEAR && wd_en_q ##1 !wdog_stat.expired && wd_en_q
      |=> wdog_stat.count == $past(period_q))
      else $error("clear command did not restart the countdown");

   c_expiry: cover property (@(posedge clk) disable iff (rst)
      wdog_stat.expired && !exp_prev_q);
   c_hot_reload: cover property (@(posedge clk) disable iff (rst)
      hot_rise && !ret_s2_q);
   c_discard: cover property (@(posedge clk) disable iff (rst)
      wr_fire && wr_discard);
   c_irq: cover property (@(posedge clk) disable iff (rst) irq);
endmodule : out_card

//--- card_pkg.sv
// Constants, field positions and carrier types shared by the output card logic.
// Assumes one 125 MHz clock and software access over a 32-bit AXI4-Lite slave.
//
// How it works
// - Output drivers stay disabled after power-up until the start state is loaded.
// - Every output line has its own start level, high or low.
// - Start levels live in storage that software writes; unwritten levels are zero.
// - Software must clear the watchdog in time, else outputs go to safe state.
// - After expiry outputs hold the safe state until disabled and rewritten.
// - While expired, host writes other than control, status and mask are dropped until the watchdog is disabled.
// - Software sets the watchdog timeout through the timeout period setting.
// - The watchdog counts 32-bit in 100 ns units, up to about seven minutes.
// - On hot reset a jumper picks retain current outputs or reload start levels.
// - Software can read back the present state of every output line.
// - Software can read the card identifier switch to tell cards apart.
package card_pkg;

   localparam int unsigned NUM_LINES = 128;
   localparam int unsigned NUM_WORDS = 4;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned ID_W = 4;
   localparam int unsigned ST_W = 3;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] OFF_OUT = 8'h00;
   localparam logic [7:0] OFF_PWR = 8'h10;
   localparam logic [7:0] OFF_SAFE = 8'h20;
   localparam logic [7:0] OFF_PERIOD = 8'h30;
   localparam logic [7:0] OFF_CTRL = 8'h34;
   localparam logic [7:0] OFF_CLEAR = 8'h38;
   localparam logic [7:0] OFF_COUNT = 8'h3C;
   localparam logic [7:0] OFF_STATUS = 8'h40;
   localparam logic [7:0] OFF_MASK = 8'h44;
   localparam logic [7:0] OFF_ID = 8'h48;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions and reset values
   localparam int unsigned CTRL_EN_BIT = 0;
   localparam int unsigned ST_EXPIRED = 0;
   localparam int unsigned ST_DISCARD = 1;
   localparam int unsigned ST_HOTRST = 2;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [31:0] RST_PERIOD = 32'hFFFF_FFFF;
   localparam logic [2:0] RST_STATUS = 3'h0;
   localparam logic [2:0] RST_MASK = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Timing: the watchdog unit is not a whole number of clocks, so a phase
   // accumulator adds the clock period and ticks each time it passes the unit
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned TICK_NS = 100;
   localparam int unsigned ACC_W = 8;
   localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(CLK_PERIOD_NS);
   localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(TICK_NS);

   typedef struct packed {
      logic enable;
      logic clear;
      logic [31:0] period;
   } wdog_cmd_type;

   typedef struct packed {
      logic expired;
      logic tick;
      logic [31:0] count;
   } wdog_stat_type;

endpackage : card_pkg

//--- wdog_timer.sv
// Watchdog countdown in 100 ns units with a 32-bit counter.
// Assumes enable, clear and period come from registers on the same clock.
`timescale 1ns/1ns
module wdog_timer (
   input wire logic clk,
   input wire logic rst,
   input card_pkg::wdog_cmd_type cmd,
   output card_pkg::wdog_stat_type stat
);
   logic [card_pkg::ACC_W-1:0] acc_q;
   logic [31:0] count_q;
   logic expired_q;
   logic tick;

   assign tick = cmd.enable && ((acc_q + card_pkg::ACC_STEP) >= card_pkg::ACC_WRAP);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_q <= '0;
      end else if (!cmd.enable) begin
         acc_q <= '0;
      end else if (tick) begin
         acc_q <= acc_q + card_pkg::ACC_STEP - card_pkg::ACC_WRAP;
      end else begin
         acc_q <= acc_q + card_pkg::ACC_STEP;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_q <= card_pkg::RST_PERIOD;
      end else if (!cmd.enable) begin
         count_q <= cmd.period;
      end else if (cmd.clear && !expired_q) begin
         count_q <= cmd.period;
      end else if (tick && count_q != 32'h0000_0000) begin
         count_q <= count_q - 32'h0000_0001;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         expired_q <= 1'b0;
      end else if (!cmd.enable) begin
         expired_q <= 1'b0;
      end else if (count_q == 32'h0000_0000) begin
         expired_q <= 1'b1;
      end
   end

   assign stat.expired = expired_q;
   assign stat.tick = tick;
   assign stat.count = count_q;

   a_wdog_reload: assert property (@(posedge clk) disable iff (rst)
      cmd.enable && cmd.clear && !expired_q |=> count_q == $past(cmd.period))
      else $error("watchdog clear did not reload the period");
   a_wdog_expire: assert property (@(posedge clk) disable iff (rst)
      cmd.enable && count_q == 32'h0000_0000 ##1 cmd.enable |-> expired_q)
      else $error("watchdog did not expire at zero");
   a_tick_spacing: assert property (@(posedge clk) disable iff (rst)
      tick |=> !tick [*8])
      else $error("watchdog ticks closer than the time unit");
endmodule : wdog_timer

//--- host_model.sv
// Host software stand-in: an AXI4-Lite master offering one write and one read task.
// Assumes slave readies and answers are registered or settled at each rising clock edge.
`timescale 1ns/1ns
module host_model (
   input wire logic clk,
   output logic [card_pkg::ADDR_W-1:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [card_pkg::ADDR_W-1:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
   end
   ////////////////////////////////////////
   // Readies and answers are taken at the rising edge that completes each handshake,
   // and each channel is released by a non-blocking update at that same edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic fa;
      logic fw;
      logic fb;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         fa = s_axi_awready;
         fw = s_axi_wready;
         fb = s_axi_bvalid;
         r = s_axi_bresp;
         if (fa) s_axi_awvalid <= 1'b0;
         if (fw) s_axi_wvalid <= 1'b0;
      end while (fb !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic fa;
      logic fr;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         fa = s_axi_arready;
         fr = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         if (fa) s_axi_arvalid <= 1'b0;
      end while (fr !== 1'b1);
      s_axi_rready <= 1'b0;
   endtask : rd
endmodule : host_model

//--- tb_top.sv
// Self-checking bench for the output card: register table, hot reset, watchdog.
// Assumes host_model drives the AXI4-Lite side; pins are driven here.
`timescale 1ns/1ns
module tb_top;
   typedef struct packed {logic we; logic [7:0] a; logic [31:0] d; logic [1:0] r;} row_type;
   localparam row_type rows [11] = '{'{1, 8'h10, 32'h0000_00A5, 2'h0},
      '{0, 8'h10, 32'h0000_00A5, 2'h0}, '{0, 8'h14, 32'h0000_0000, 2'h0},
      '{1, 8'h20, 32'h5A5A_0F0F, 2'h0}, '{0, 8'h20, 32'h5A5A_0F0F, 2'h0},
      '{1, 8'h00, 32'h1234_5678, 2'h0}, '{0, 8'h00, 32'h1234_5678, 2'h0},
      '{0, 8'h30, 32'hFFFF_FFFF, 2'h0}, '{0, 8'h48, 32'h0000_0009, 2'h0},
      '{1, 8'h50, 32'h0000_0000, 2'h2}, '{0, 8'h50, 32'h0000_0000, 2'h2}};
   logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic hot_reset, retain_jumper, dout_en, irq;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb, card_identifier_switch;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [127:0] dout;
   int err_count = 0;
   int compares = 0;
   int n;
   out_card dut_u (.*);
   host_model host_u (.*);
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic chk(input logic [127:0] s, input logic [127:0] e, input string nm);
      compares++;
      if (s !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic pulse(input logic j);
      @(posedge clk) retain_jumper <= j;
      repeat (4) @(posedge clk);
      hot_reset <= 1'b1;
      repeat (4) @(posedge clk);
      hot_reset <= 1'b0;
      repeat (6) @(negedge clk);
   endtask : pulse
   task automatic final_report();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : final_report
   initial begin
      repeat (3000) @(posedge clk);
      err_count++;
      final_report();
   end
   ////////////////////////////////////////
   initial begin
      rst = 1'b1;
      hot_reset = 1'b0;
      retain_jumper = 1'b1;
      card_identifier_switch = 4'h9;
      repeat (2) @(posedge clk);
      chk(dout_en, 1'b0, "dout_en in reset");
      chk(dout, 128'h0, "dout in reset");
      rst <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      chk(dout_en, 1'b1, "dout_en after reset");
      chk(dout, 128'h0, "start levels");
      $display("test reset done");
      foreach (rows[i]) begin
         if (rows[i].we) begin
            host_u.wr(rows[i].a, rows[i].d, r);
            chk(r, rows[i].r, "bresp");
         end else begin
            host_u.rd(rows[i].a, d, r);
            chk(d, rows[i].d, "rdata");
            chk(r, rows[i].r, "rresp");
         end
      end
      $display("test table done");
      pulse(1'b1);
      chk(dout[31:0], 32'h1234_5678, "retained");
      pulse(1'b0);
      chk(dout[31:0], 32'h0000_00A5, "reloaded");
      host_u.rd(8'h40, d, r);
      chk(d, 32'h0000_0004, "hot status");
      host_u.wr(8'h40, 32'h0000_0007, r);
      $display("test hot reset done");
      host_u.wr(8'h30, 32'h0000_0003, r);
      host_u.wr(8'h44, 32'h0000_0001, r);
      host_u.wr(8'h34, 32'h0000_0001, r);
      // Clears spaced well inside three ticks, over more than the whole period
      repeat (12) host_u.wr(8'h38, 32'h0000_0001, r);
      @(negedge clk);
      chk(irq, 1'b0, "alive");
      repeat (24) @(negedge clk);
      chk(irq, 1'b0, "early");
      n = 0;
      while (irq !== 1'b1 && n < 30) begin
         @(negedge clk);
         n++;
      end
      chk(irq, 1'b1, "expired");
      @(negedge clk);
      chk(dout, {96'h0, 32'h5A5A_0F0F}, "safe");
      host_u.wr(8'h00, 32'hFFFF_FFFF, r);
      @(negedge clk);
      chk(dout[31:0], 32'h5A5A_0F0F, "dropped");
      host_u.rd(8'h40, d, r);
      chk(d, 32'h0000_0003, "drop status");
      host_u.wr(8'h44, 32'h0000_0000, r);
      @(negedge clk);
      chk(irq, 1'b0, "masked");
      host_u.wr(8'h44, 32'h0000_0001, r);
      host_u.wr(8'h34, 32'h0000_0000, r);
      @(negedge clk);
      chk(irq, 1'b1, "unmasked");
      chk(dout[31:0], 32'h5A5A_0F0F, "held");
      host_u.wr(8'h00, 32'h0000_0042, r);
      host_u.wr(8'h40, 32'h0000_0007, r);
      @(negedge clk);
      chk(dout[31:0], 32'h0000_0042, "rewritten");
      chk(irq, 1'b0, "cleared");
      $display("test watchdog done");
      @(posedge clk) rst <= 1'b1;
      @(negedge clk);
      chk(dout_en, 1'b0, "dout_en in second reset");
      chk(dout, 128'h0, "dout in second reset");
      chk(irq, 1'b0, "irq in second reset");
      @(posedge clk) rst <= 1'b0;
      @(negedge clk);
      chk(dout_en, 1'b0, "dout_en before start load");
      @(negedge clk);
      chk(dout_en, 1'b1, "dout_en after second reset");
      chk(dout, 128'h0, "start levels after second reset");
      $display("test second reset done");
      final_report();
   end
endmodule : tb_top
